// File: design/track_acq_pkg.sv
/*
  Constants for the track, acquire and reset control block.
  Assumes a single 100 MHz clock.
*/
package track_acq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_MIN_NS = 90;
  localparam int RST_MAX_NS = 200;
  localparam int ACQ_MAX_US = 16;
  // Least time rounds up, longest time rounds down
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_MAX_CYC = RST_MAX_NS / CLK_PERIOD_NS;
  localparam int ACQ_MAX_CYC = (ACQ_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int ACQ_CYC_DEF = 1000;
  localparam int LOW_CNT_W = 8;
  localparam int ACQ_CNT_W = 16;
  localparam int CH_W = 5;
  localparam logic [LOW_CNT_W-1:0] LOW_CNT_MAX = 8'hff;
endpackage : track_acq_pkg

// File: design/track_acquire_reset_control.sv
/*
  Track, acquisition and reset control of a multichannel sample-and-hold converter.
  Assumes pins are synchronous to MCLK; the pin pull devices are modelled as the
  defaults seen by the external wire resolution (select low, track high).
*/
`timescale 1ns/1ps
module track_acquire_reset_control
  import track_acq_pkg::*;
#(
  parameter int ACQ_CYC = ACQ_CYC_DEF
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Host pins
  input wire logic INTERFACE_SELECT,
  input wire logic TRACK,
  // Channel address strobe from the interface logic
  input wire logic ADDR_VALID,
  input wire logic [track_acq_pkg::CH_W-1:0] ADDR_CH,
  // Status and routing
  output logic BUSY_N,
  output logic SERIAL_SEL,
  output logic VIN_ROUTE,
  output logic [track_acq_pkg::CH_W-1:0] ACQ_CH,
  output logic DEV_RESET
);
  import track_acq_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ACQ} acq_state_e;

  acq_state_e state_q;
  logic track_q;
  logic [LOW_CNT_W-1:0] low_cnt_q;
  logic [ACQ_CNT_W-1:0] acq_cnt_q;
  logic track_rise;
  logic rst_pulse;
  logic soft_rst;

  // ==========================================
  // Track low-phase timing
  assign track_rise = TRACK && !track_q;
  assign rst_pulse = track_rise && (low_cnt_q >= LOW_CNT_W'(RST_MIN_CYC))
                     && (low_cnt_q <= LOW_CNT_W'(RST_MAX_CYC));
  assign soft_rst = DEV_RESET;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      track_q <= 1'b1;
      low_cnt_q <= '0;
    end else begin
      track_q <= TRACK;
      if (TRACK) begin
        low_cnt_q <= '0;
      end else if (low_cnt_q != LOW_CNT_MAX) begin
        low_cnt_q <= low_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      DEV_RESET <= 1'b0;
    end else begin
      DEV_RESET <= rst_pulse;
    end
  end

  // ==========================================
  // Interface selection
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SERIAL_SEL <= 1'b0;
    end else begin
      SERIAL_SEL <= INTERFACE_SELECT;
    end
  end

  // ==========================================
  // Acquisition sequencing
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= S_IDLE;
      acq_cnt_q <= '0;
      ACQ_CH <= '0;
      BUSY_N <= 1'b1;
      VIN_ROUTE <= 1'b0;
    end else if (soft_rst) begin
      state_q <= S_IDLE;
      acq_cnt_q <= '0;
      ACQ_CH <= '0;
      BUSY_N <= 1'b1;
      VIN_ROUTE <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE, S_WAIT: begin
          if (ADDR_VALID) begin
            ACQ_CH <= ADDR_CH;
          end
          if (ADDR_VALID && TRACK) begin
            state_q <= S_ACQ;
            acq_cnt_q <= '0;
            BUSY_N <= 1'b0;
            VIN_ROUTE <= 1'b1;
          end else if (ADDR_VALID) begin
            state_q <= S_WAIT;
            VIN_ROUTE <= 1'b1;
          end else if (state_q == S_WAIT && track_rise && !rst_pulse
                       && low_cnt_q > LOW_CNT_W'(RST_MAX_CYC)) begin
            state_q <= S_ACQ;
            acq_cnt_q <= '0;
            BUSY_N <= 1'b0;
          end
        end
        S_ACQ: begin
          if (acq_cnt_q == ACQ_CNT_W'(ACQ_CYC - 1)) begin
            state_q <= S_IDLE;
            BUSY_N <= 1'b1;
            VIN_ROUTE <= 1'b0;
          end else begin
            acq_cnt_q <= acq_cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= S_IDLE;
          BUSY_N <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // Assertions
  property p_reset_pulse;
    @(posedge MCLK) disable iff (!RST_N)
      rst_pulse |=> DEV_RESET ##1 (BUSY_N && state_q == S_IDLE);
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse not honoured");

  property p_glitch;
    @(posedge MCLK) disable iff (!RST_N)
      (track_rise && low_cnt_q < LOW_CNT_W'(RST_MIN_CYC)) |=> !DEV_RESET;
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch caused a reset");

  property p_immediate;
    @(posedge MCLK) disable iff (!RST_N || soft_rst)
      (ADDR_VALID && TRACK && state_q != S_ACQ) |=> !BUSY_N;
  endproperty
  a_immediate: assert property (p_immediate) else $error("acquisition did not start");

  property p_hold_low;
    @(posedge MCLK) disable iff (!RST_N || soft_rst)
      (state_q == S_WAIT && !TRACK) |=> BUSY_N && VIN_ROUTE;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("acquired while track low");

  property p_rise_start;
    @(posedge MCLK) disable iff (!RST_N || soft_rst)
      (state_q == S_WAIT && !ADDR_VALID && track_rise && low_cnt_q > LOW_CNT_W'(RST_MAX_CYC)) |=> !BUSY_N;
  endproperty
  a_rise_start: assert property (p_rise_start) else $error("no start on track rise");

  property p_busy_state;
    @(posedge MCLK) disable iff (!RST_N)
      (!BUSY_N) == (state_q == S_ACQ);
  endproperty
  a_busy_state: assert property (p_busy_state) else $error("busy disagrees with acquisition");

  property p_acq_bound;
    @(posedge MCLK) disable iff (!RST_N)
      acq_cnt_q < ACQ_CNT_W'(ACQ_MAX_CYC);
  endproperty
  a_acq_bound: assert property (p_acq_bound) else $error("acquisition too long");

  property p_select;
    @(posedge MCLK) disable iff (!RST_N)
      ##1 SERIAL_SEL == $past(INTERFACE_SELECT);
  endproperty
  a_select: assert property (p_select) else $error("interface select wrong");

  property p_count;
    @(posedge MCLK) disable iff (!RST_N)
      (!TRACK && low_cnt_q != LOW_CNT_MAX) |=> low_cnt_q == $past(low_cnt_q) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("low counter stalled");

  property p_route_acq;
    @(posedge MCLK) disable iff (!RST_N)
      !BUSY_N |-> VIN_ROUTE;
  endproperty
  a_route_acq: assert property (p_route_acq) else $error("input not routed during acquisition");

  property p_route_done;
    @(posedge MCLK) disable iff (!RST_N)
      $rose(BUSY_N) |-> !VIN_ROUTE;
  endproperty
  a_route_done: assert property (p_route_done) else $error("input still routed after acquisition");

  property p_glitch_wait;
    @(posedge MCLK) disable iff (!RST_N || soft_rst)
      (state_q == S_WAIT && !ADDR_VALID && track_rise && low_cnt_q < LOW_CNT_W'(RST_MIN_CYC)) |=> (state_q == S_WAIT && BUSY_N);
  endproperty
  a_glitch_wait: assert property (p_glitch_wait) else $error("glitch ended the deferred wait");

  property p_ch_capture;
    @(posedge MCLK) disable iff (!RST_N || soft_rst)
      (ADDR_VALID && state_q != S_ACQ) |=> ACQ_CH == $past(ADDR_CH);
  endproperty
  a_ch_capture: assert property (p_ch_capture) else $error("addressed channel not taken");

  c_reset: cover property (@(posedge MCLK) disable iff (!RST_N) rst_pulse);
  c_acq_done: cover property (@(posedge MCLK) disable iff (!RST_N) !BUSY_N ##1 BUSY_N);
  c_deferred: cover property (@(posedge MCLK) disable iff (!RST_N) state_q == S_WAIT ##1 state_q == S_ACQ);
  c_glitch: cover property (@(posedge MCLK) disable iff (!RST_N)
    state_q == S_WAIT && track_rise && low_cnt_q < LOW_CNT_W'(RST_MIN_CYC));
  c_track_long: cover property (@(posedge MCLK) disable iff (!RST_N)
    track_rise && low_cnt_q > LOW_CNT_W'(RST_MAX_CYC));
endmodule : track_acquire_reset_control

// File: dv/host_model.sv
/*
  Host controller model driving the track and select pins.
  Assumes MCLK from the bench; a released pin falls to its pull level.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic MCLK,
  output logic TRACK,
  output logic INTERFACE_SELECT
);
  logic trk_en = 1'b0;
  logic trk_v = 1'b0;
  logic sel_en = 1'b0;
  logic sel_v = 1'b0;
  assign TRACK = trk_en ? trk_v : 1'b1;
  assign INTERFACE_SELECT = sel_en ? sel_v : 1'b0;
  // Low phase of n sampled cycles, then one driven high cycle before release
  task automatic low_pulse(input int n);
    @(posedge MCLK);
    trk_en <= 1'b1;
    trk_v <= 1'b0;
    repeat (n) @(posedge MCLK);
    trk_v <= 1'b1;
    @(posedge MCLK);
    trk_en <= 1'b0;
  endtask : low_pulse
  task automatic drive_sel(input logic en, input logic v);
    @(posedge MCLK);
    sel_en <= en;
    sel_v <= v;
  endtask : drive_sel
endmodule : host_model

// File: dv/track_acquire_reset_control_tb.sv
/*
  Bench for the track, acquisition and reset control block.
  Assumes the design package and the host model.
*/
`timescale 1ns/1ps
module track_acquire_reset_control_tb;
  import track_acq_pkg::*;
  localparam int ACQ = 40;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic ADDR_VALID = 1'b0;
  logic [CH_W-1:0] ADDR_CH = '0;
  logic TRACK, INTERFACE_SELECT, BUSY_N, SERIAL_SEL, VIN_ROUTE, DEV_RESET;
  logic [CH_W-1:0] ACQ_CH;
  int fails = 0;
  int n_compared = 0;
  initial forever #5 MCLK = ~MCLK;
  host_model u_host_model (.MCLK(MCLK), .TRACK(TRACK), .INTERFACE_SELECT(INTERFACE_SELECT));
  track_acquire_reset_control #(.ACQ_CYC(ACQ)) u_track_acquire_reset_control (.MCLK(MCLK), .RST_N(RST_N),
    .INTERFACE_SELECT(INTERFACE_SELECT), .TRACK(TRACK), .ADDR_VALID(ADDR_VALID), .ADDR_CH(ADDR_CH),
    .BUSY_N(BUSY_N), .SERIAL_SEL(SERIAL_SEL), .VIN_ROUTE(VIN_ROUTE), .ACQ_CH(ACQ_CH), .DEV_RESET(DEV_RESET));
  // ==========
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic addr(input logic [CH_W-1:0] ch);
    @(posedge MCLK);
    ADDR_VALID <= 1'b1;
    ADDR_CH <= ch;
    @(posedge MCLK);
    ADDR_VALID <= 1'b0;
    #1;
  endtask : addr
  task automatic busy_len(output int len);
    len = 0;
    while (BUSY_N === 1'b0 && len < 100) begin
      @(posedge MCLK);
      #1;
      len++;
    end
  endtask : busy_len
  task automatic rst_try(input int len, input int exp);
    int c;
    c = 0;
    fork
      u_host_model.low_pulse(len);
      repeat (len + 6) begin
        @(posedge MCLK);
        #1;
        if (DEV_RESET === 1'b1) c++;
      end
    join
    check("dev_reset", c, exp);
  endtask : rst_try
  task automatic test_select;
    @(posedge MCLK);
    #1;
    check("busy_n", BUSY_N, 1'b1);
    u_host_model.drive_sel(1'b1, 1'b1);
    @(posedge MCLK);
    #1;
    check("serial_sel", SERIAL_SEL, 1'b1);
    u_host_model.drive_sel(1'b0, 1'b1);
    @(posedge MCLK);
    #1;
    check("serial_sel", SERIAL_SEL, 1'b0);
    $display("select test done");
  endtask : test_select
  task automatic test_acquire;
    int len;
    addr(5'h1f);
    check("busy_n", BUSY_N, 1'b0);
    check("vin_route", VIN_ROUTE, 1'b1);
    addr(5'h03);
    busy_len(len);
    check("busy_len", len, ACQ - 2);
    check("acq_ch", ACQ_CH, 5'h1f);
    check("vin_route", VIN_ROUTE, 1'b0);
    $display("acquire test done");
  endtask : test_acquire
  task automatic test_deferred;
    int len;
    // Address while track is low, then a glitch rise that must not start it
    fork
      u_host_model.low_pulse(5);
      addr(5'h07);
    join
    repeat (3) @(posedge MCLK);
    #1;
    check("busy_n", BUSY_N, 1'b1);
    check("vin_route", VIN_ROUTE, 1'b1);
    fork
      u_host_model.low_pulse(30);
      begin
        repeat (20) @(posedge MCLK);
        #1;
        check("busy_n", BUSY_N, 1'b1);
      end
    join
    #1;
    check("busy_n", BUSY_N, 1'b0);
    busy_len(len);
    check("busy_len", len, ACQ);
    check("acq_ch", ACQ_CH, 5'h07);
    $display("deferred test done");
  endtask : test_deferred
  task automatic test_reset;
    rst_try(8, 0);
    rst_try(9, 1);
    rst_try(20, 1);
    rst_try(21, 0);
    addr(5'h0a);
    check("busy_n", BUSY_N, 1'b0);
    rst_try(10, 1);
    check("busy_n", BUSY_N, 1'b1);
    check("acq_ch", ACQ_CH, 5'h00);
    $display("reset test done");
  endtask : test_reset
  // ==========
  // Main sequence
  initial begin
    repeat (5) @(posedge MCLK);
    RST_N <= 1'b1;
    test_select;
    test_acquire;
    test_deferred;
    test_reset;
    test_done;
  end
  initial begin
    #20000;
    fails++;
    test_done;
  end
endmodule : track_acquire_reset_control_tb
